//--- core/acqtw_pkg.sv
// Constants, types and register map of the acquisition trigger wait block.
// Assumes a single 50 MHz clock and an AXI4-Lite register bus.
package acqtw_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_NS         = 20;
  localparam int unsigned EXP_DLY_MIN_NS = 19340;
  localparam int unsigned EXP_DLY_MAX_NS = 180000;
  localparam int unsigned EXP_DLY_CYC    = (EXP_DLY_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TX_START_CYC   = 64;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CMD      = 8'h04;
  localparam logic [7:0] ADDR_FRAMES   = 8'h08;
  localparam logic [7:0] ADDR_EXPOSE   = 8'h0c;
  localparam logic [7:0] ADDR_HEIGHT   = 8'h10;
  localparam logic [7:0] ADDR_LINE_K   = 8'h14;
  localparam logic [7:0] ADDR_FIXED_K  = 8'h18;
  localparam logic [7:0] ADDR_TX_TIME  = 8'h1c;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h20;
  localparam logic [7:0] ADDR_LINE_SEL = 8'h24;
  localparam logic [7:0] ADDR_LINE_SRC = 8'h28;
  localparam logic [7:0] ADDR_STATUS   = 8'h2c;
  localparam logic [7:0] ADDR_MASK     = 8'h30;
  localparam logic [7:0] ADDR_STATE    = 8'h34;

  // ==========================================================
  // Field positions
  localparam int CTRL_STD      = 0;
  localparam int CTRL_HW_ACQ   = 1;
  localparam int CTRL_HW_FRAME = 2;
  localparam int CTRL_DEB_EN   = 3;
  localparam int CTRL_RUN      = 4;
  localparam int CMD_SW_ACQ    = 0;
  localparam int EV_ACQ_OVER   = 0;
  localparam int EV_ACQ_START  = 1;
  localparam int EV_FRM_OVER   = 2;
  localparam int EV_FRM_SENT   = 3;
  localparam int EV_W          = 4;

  // ==========================================================
  // Reset values
  localparam logic [31:0] CTRL_RST    = 32'h0000_0007;
  localparam logic [31:0] FRAMES_RST  = 32'h0000_0001;
  localparam logic [31:0] EXPOSE_RST  = 32'h0000_03e8;
  localparam logic [31:0] HEIGHT_RST  = 32'h0000_01e0;
  localparam logic [31:0] LINE_K_RST  = 32'h0000_0400;
  localparam logic [31:0] FIXED_K_RST = 32'h0000_4000;
  localparam logic [31:0] ZERO_RST    = 32'h0000_0000;

  localparam logic [1:0] RESP_OK     = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {LSRC_OFF, LSRC_WAIT, LSRC_EXPOSE, LSRC_READ} acqtw_lsrc_t;
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_WAIT, ACQ_ACTIVE} acqtw_acq_t;
  typedef enum logic [1:0] {EXP_IDLE, EXP_DELAY, EXP_ON, EXP_HOLD} acqtw_exp_t;
  typedef enum logic [1:0] {TX_IDLE, TX_PEND, TX_SEND} acqtw_tx_t;

endpackage

//--- core/acqtw_tmr_if.sv
// Interface between the sequencer and its down-counting timers.
// Assumes both ends share the block clock.
interface acqtw_tmr_if;
  logic        load;
  logic [31:0] count;
  logic        busy;
  logic        done;
  logic [31:0] remain;
  modport ctrl  (output load, count, input busy, done, remain);
  modport timer (input load, count, output busy, done, remain);
endinterface

//--- core/acqtw_timer.sv
// Down-counting interval timer: load starts a run of count cycles.
// Assumes load is a one-cycle pulse from the same clock domain.
module acqtw_timer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Control
  acqtw_tmr_if.timer       tmr
);
  logic [31:0] remain;
  logic [31:0] next_remain;
  logic        done;
  logic        next_done;

  always_comb begin
    next_remain = remain;
    next_done   = 1'b0;
    if (tmr.load) begin
      // A zero count still takes one cycle, so done always follows load
      next_remain = (tmr.count == 32'h0) ? 32'h1 : tmr.count;
    end else if (remain != 32'h0) begin
      next_remain = remain - 32'h1;
      next_done   = (remain == 32'h1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      remain <= 32'h0;
      done   <= 1'b0;
    end else begin
      remain <= next_remain;
      done   <= next_done;
    end
  end

  assign tmr.busy   = (remain != 32'h0);
  assign tmr.done   = done;
  assign tmr.remain = remain;
endmodule // acqtw_timer

//--- core/acqtw_seq.sv
// Acquisition start wait flag, trigger handling, exposure, readout and
// transmission sequencing, with an AXI4-Lite register slave.
// Assumes trigger pins are asynchronous and net_ready comes from same-clock logic.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
module acqtw_seq #(
  parameter int unsigned EXP_DLY_CYC  = acqtw_pkg::EXP_DLY_CYC,
  parameter int unsigned TX_START_CYC = acqtw_pkg::TX_START_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Trigger pins and output lines
  input  wire logic        ext_acq_begin_trigger_in,
  input  wire logic        ext_exposure_trigger_in,
  output logic [3:0]       line_out,
  // Sensor and link status
  input  wire logic        net_ready,
  output logic             acq_wait_flag,
  output logic             exposing,
  output logic             reading_out,
  output logic             tx_active,
  output logic             irq
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
    return (a > b) ? a : b;
  endfunction

  // ==========================================================
  // Register state
  logic [31:0] ctrl, frames, expose, height, line_k, fixed_k, tx_time, debounce;
  logic [31:0] next_ctrl, next_frames, next_expose, next_height;
  logic [31:0] next_line_k, next_fixed_k, next_tx_time, next_debounce;
  logic [1:0]  line_sel, next_line_sel;
  acqtw_pkg::acqtw_lsrc_t line_src [4];
  acqtw_pkg::acqtw_lsrc_t next_line_src [4];
  logic [acqtw_pkg::EV_W-1:0] status, next_status, mask, next_mask, events;
  logic        sw_acq, next_sw_acq;

  // Bus state
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic        do_write, wr_ok;

  // ==========================================================
  // AXI4-Lite channels
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;
  assign do_write      = aw_held && w_held && !bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_ok ? acqtw_pkg::RESP_OK : acqtw_pkg::RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // ==========================================================
  // Register writes
  always_comb begin
    logic [acqtw_pkg::EV_W-1:0] clr;
    clr           = '0;
    wr_ok         = 1'b1;
    next_ctrl     = ctrl;
    next_frames   = frames;
    next_expose   = expose;
    next_height   = height;
    next_line_k   = line_k;
    next_fixed_k  = fixed_k;
    next_tx_time  = tx_time;
    next_debounce = debounce;
    next_line_sel = line_sel;
    next_line_src = line_src;
    next_mask     = mask;
    next_sw_acq   = 1'b0;
    if (do_write) begin
      case (aw_addr)
        acqtw_pkg::ADDR_CTRL:     next_ctrl     = merge(ctrl, w_data, w_strb);
        acqtw_pkg::ADDR_CMD:      next_sw_acq   = w_strb[0] && w_data[acqtw_pkg::CMD_SW_ACQ];
        acqtw_pkg::ADDR_FRAMES:   next_frames   = merge(frames, w_data, w_strb);
        acqtw_pkg::ADDR_EXPOSE:   next_expose   = merge(expose, w_data, w_strb);
        acqtw_pkg::ADDR_HEIGHT:   next_height   = merge(height, w_data, w_strb);
        acqtw_pkg::ADDR_LINE_K:   next_line_k   = merge(line_k, w_data, w_strb);
        acqtw_pkg::ADDR_FIXED_K:  next_fixed_k  = merge(fixed_k, w_data, w_strb);
        acqtw_pkg::ADDR_TX_TIME:  next_tx_time  = merge(tx_time, w_data, w_strb);
        acqtw_pkg::ADDR_DEBOUNCE: next_debounce = merge(debounce, w_data, w_strb);
        acqtw_pkg::ADDR_LINE_SEL: begin
          if (w_strb[0]) next_line_sel = w_data[1:0];
        end
        acqtw_pkg::ADDR_LINE_SRC: begin
          // Source lands on whichever line was selected beforehand
          if (w_strb[0]) next_line_src[line_sel] = acqtw_pkg::acqtw_lsrc_t'(w_data[1:0]);
        end
        acqtw_pkg::ADDR_STATUS: begin
          if (w_strb[0]) clr = w_data[acqtw_pkg::EV_W-1:0];
        end
        acqtw_pkg::ADDR_MASK: begin
          if (w_strb[0]) next_mask = w_data[acqtw_pkg::EV_W-1:0];
        end
        acqtw_pkg::ADDR_STATE: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
    end
    // A new event wins over a clear in the same cycle
    next_status = (status & ~clr) | events;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      aw_held  <= 1'b0;
      aw_addr  <= 8'h0;
      w_held   <= 1'b0;
      w_data   <= 32'h0;
      w_strb   <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= acqtw_pkg::RESP_OK;
      ctrl     <= acqtw_pkg::CTRL_RST;
      frames   <= acqtw_pkg::FRAMES_RST;
      expose   <= acqtw_pkg::EXPOSE_RST;
      height   <= acqtw_pkg::HEIGHT_RST;
      line_k   <= acqtw_pkg::LINE_K_RST;
      fixed_k  <= acqtw_pkg::FIXED_K_RST;
      tx_time  <= acqtw_pkg::ZERO_RST;
      debounce <= acqtw_pkg::ZERO_RST;
      line_sel <= 2'h0;
      line_src <= '{default: acqtw_pkg::LSRC_OFF};
      status   <= '0;
      mask     <= '0;
      sw_acq   <= 1'b0;
    end else begin
      aw_held  <= next_aw_held;
      aw_addr  <= next_aw_addr;
      w_held   <= next_w_held;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      ctrl     <= next_ctrl;
      frames   <= next_frames;
      expose   <= next_expose;
      height   <= next_height;
      line_k   <= next_line_k;
      fixed_k  <= next_fixed_k;
      tx_time  <= next_tx_time;
      debounce <= next_debounce;
      line_sel <= next_line_sel;
      line_src <= next_line_src;
      status   <= next_status;
      mask     <= next_mask;
      sw_acq   <= next_sw_acq;
    end
  end

  // ==========================================================
  // Sequencer state
  acqtw_pkg::acqtw_acq_t acq, next_acq;
  acqtw_pkg::acqtw_exp_t exp_st, next_exp_st;
  acqtw_pkg::acqtw_tx_t  tx_st, next_tx_st;
  logic [31:0] frames_left, next_frames_left, ro_total, next_ro_total;
  logic [2:0]  acq_sync, exp_sync;
  logic        acq_edge, exp_edge, acq_trig, frame_trig, frame_edge_mode;
  logic        std_mode, hw_acq, next_wait_flag;
  logic [3:0]  next_line_out;

  acqtw_tmr_if t_exp ();
  acqtw_tmr_if t_ro ();
  acqtw_tmr_if t_tx ();

  acqtw_timer u_t_exp (.clock(clock), .rst_b(rst_b), .tmr(t_exp));
  acqtw_timer u_t_ro  (.clock(clock), .rst_b(rst_b), .tmr(t_ro));
  acqtw_timer u_t_tx  (.clock(clock), .rst_b(rst_b), .tmr(t_tx));

  // Edges are taken only from the second and third stages
  assign acq_edge = acq_sync[1] && !acq_sync[2];
  assign exp_edge = exp_sync[1] && !exp_sync[2];
  assign std_mode = ctrl[acqtw_pkg::CTRL_STD];
  assign hw_acq   = ctrl[acqtw_pkg::CTRL_HW_ACQ];

  always_comb begin
    // Legacy mode turns the exposure pin into the acquisition start
    if (hw_acq) acq_trig = std_mode ? acq_edge : exp_edge;
    else        acq_trig = sw_acq;
    frame_edge_mode = std_mode && ctrl[acqtw_pkg::CTRL_HW_FRAME];
    frame_trig      = frame_edge_mode ? exp_edge : 1'b1;
  end

  // ==========================================================
  // Acquisition, exposure and transmission sequencing
  always_comb begin
    logic start_frame, exp_end, ro_free;
    logic [31:0] elapsed;
    next_acq         = acq;
    next_exp_st      = exp_st;
    next_tx_st       = tx_st;
    next_frames_left = frames_left;
    next_ro_total    = ro_total;
    events           = '0;
    t_exp.load       = 1'b0;
    t_exp.count      = expose;
    t_ro.load        = 1'b0;
    t_ro.count       = 32'((height + 32'h1) * line_k) + fixed_k;
    t_tx.load        = 1'b0;
    t_tx.count       = max32(tx_time, ro_total);
    start_frame      = (acq == acqtw_pkg::ACQ_ACTIVE) && (exp_st == acqtw_pkg::EXP_IDLE)
                       && (frames_left != 32'h0) && frame_trig;
    exp_end          = (exp_st == acqtw_pkg::EXP_ON) && t_exp.done;
    // One frame buffer: a new readout waits until the previous frame has left
    ro_free          = !t_ro.busy && (tx_st == acqtw_pkg::TX_IDLE);
    elapsed          = ro_total - t_ro.remain;

    if (acq_trig && acq != acqtw_pkg::ACQ_WAIT) begin
      events[acqtw_pkg::EV_ACQ_OVER] = 1'b1;
    end
    if (frame_edge_mode && exp_edge && acq == acqtw_pkg::ACQ_ACTIVE && !start_frame) begin
      events[acqtw_pkg::EV_FRM_OVER] = 1'b1;
    end

    case (acq)
      acqtw_pkg::ACQ_IDLE: begin
        if (ctrl[acqtw_pkg::CTRL_RUN]) next_acq = acqtw_pkg::ACQ_WAIT;
      end
      acqtw_pkg::ACQ_WAIT: begin
        if (!ctrl[acqtw_pkg::CTRL_RUN]) begin
          next_acq = acqtw_pkg::ACQ_IDLE;
        end else if (acq_trig) begin
          next_acq         = acqtw_pkg::ACQ_ACTIVE;
          next_frames_left = (frames == 32'h0) ? 32'h1 : frames;
          events[acqtw_pkg::EV_ACQ_START] = 1'b1;
        end
      end
      acqtw_pkg::ACQ_ACTIVE: begin
        if (start_frame) next_frames_left = frames_left - 32'h1;
        if (!ctrl[acqtw_pkg::CTRL_RUN]) begin
          next_acq = acqtw_pkg::ACQ_IDLE;
        end else if (exp_end && frames_left == 32'h0) begin
          next_acq = acqtw_pkg::ACQ_WAIT;
        end
      end
      default: next_acq = acqtw_pkg::ACQ_IDLE;
    endcase

    case (exp_st)
      acqtw_pkg::EXP_IDLE: begin
        if (start_frame) begin
          t_exp.load  = 1'b1;
          t_exp.count = 32'(EXP_DLY_CYC);
          if (ctrl[acqtw_pkg::CTRL_DEB_EN]) begin
            t_exp.count = 32'(EXP_DLY_CYC) + debounce;
          end
          next_exp_st = acqtw_pkg::EXP_DELAY;
        end
      end
      acqtw_pkg::EXP_DELAY: begin
        if (t_exp.done) begin
          t_exp.load  = 1'b1;
          next_exp_st = acqtw_pkg::EXP_ON;
        end
      end
      acqtw_pkg::EXP_ON, acqtw_pkg::EXP_HOLD: begin
        if ((t_exp.done || exp_st == acqtw_pkg::EXP_HOLD) && ro_free) begin
          t_ro.load     = 1'b1;
          next_ro_total = t_ro.count;
          next_exp_st   = acqtw_pkg::EXP_IDLE;
          next_tx_st    = acqtw_pkg::TX_PEND;
        end else if (t_exp.done) begin
          next_exp_st = acqtw_pkg::EXP_HOLD;
        end
      end
      default: next_exp_st = acqtw_pkg::EXP_IDLE;
    endcase

    case (tx_st)
      acqtw_pkg::TX_IDLE: ;
      acqtw_pkg::TX_PEND: begin
        // Start past the fill threshold or once readout ends, and only when the link allows
        if ((elapsed >= 32'(TX_START_CYC) || !t_ro.busy) && net_ready) begin
          t_tx.load  = 1'b1;
          next_tx_st = acqtw_pkg::TX_SEND;
        end
      end
      acqtw_pkg::TX_SEND: begin
        if (t_tx.done) begin
          next_tx_st = acqtw_pkg::TX_IDLE;
          events[acqtw_pkg::EV_FRM_SENT] = 1'b1;
        end
      end
      default: next_tx_st = acqtw_pkg::TX_IDLE;
    endcase

    // Flag only offered in standard mode with hardware start triggering
    next_wait_flag = (next_acq == acqtw_pkg::ACQ_WAIT) && std_mode && hw_acq;
    for (int i = 0; i < 4; i++) begin
      case (line_src[i])
        acqtw_pkg::LSRC_WAIT:   next_line_out[i] = next_wait_flag;
        acqtw_pkg::LSRC_EXPOSE: next_line_out[i] = (next_exp_st == acqtw_pkg::EXP_ON);
        acqtw_pkg::LSRC_READ:   next_line_out[i] = t_ro.busy;
        default:                next_line_out[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      acq_sync      <= 3'h0;
      exp_sync      <= 3'h0;
      acq           <= acqtw_pkg::ACQ_IDLE;
      exp_st        <= acqtw_pkg::EXP_IDLE;
      tx_st         <= acqtw_pkg::TX_IDLE;
      frames_left   <= 32'h0;
      ro_total      <= 32'h0;
      acq_wait_flag <= 1'b0;
      line_out      <= 4'h0;
      exposing      <= 1'b0;
      tx_active     <= 1'b0;
    end else begin
      acq_sync      <= {acq_sync[1:0], ext_acq_begin_trigger_in};
      exp_sync      <= {exp_sync[1:0], ext_exposure_trigger_in};
      acq           <= next_acq;
      exp_st        <= next_exp_st;
      tx_st         <= next_tx_st;
      frames_left   <= next_frames_left;
      ro_total      <= next_ro_total;
      acq_wait_flag <= next_wait_flag;
      line_out      <= next_line_out;
      exposing      <= (next_exp_st == acqtw_pkg::EXP_ON);
      tx_active     <= (next_tx_st == acqtw_pkg::TX_SEND);
    end
  end

  assign reading_out = t_ro.busy;
  assign irq         = |(status & mask);

  // ==========================================================
  // Register reads
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = acqtw_pkg::RESP_OK;
      next_rdata  = 32'h0;
      case (s_axi_araddr)
        acqtw_pkg::ADDR_CTRL:     next_rdata = ctrl;
        acqtw_pkg::ADDR_CMD:      next_rdata = 32'h0;
        acqtw_pkg::ADDR_FRAMES:   next_rdata = frames;
        acqtw_pkg::ADDR_EXPOSE:   next_rdata = expose;
        acqtw_pkg::ADDR_HEIGHT:   next_rdata = height;
        acqtw_pkg::ADDR_LINE_K:   next_rdata = line_k;
        acqtw_pkg::ADDR_FIXED_K:  next_rdata = fixed_k;
        acqtw_pkg::ADDR_TX_TIME:  next_rdata = tx_time;
        acqtw_pkg::ADDR_DEBOUNCE: next_rdata = debounce;
        acqtw_pkg::ADDR_LINE_SEL: next_rdata[1:0] = line_sel;
        acqtw_pkg::ADDR_LINE_SRC: next_rdata[1:0] = line_src[line_sel];
        acqtw_pkg::ADDR_STATUS:   next_rdata[acqtw_pkg::EV_W-1:0] = status;
        acqtw_pkg::ADDR_MASK:     next_rdata[acqtw_pkg::EV_W-1:0] = mask;
        acqtw_pkg::ADDR_STATE:    next_rdata = {frames_left[15:0], 7'h0, acq_wait_flag,
                                               2'(tx_st), 2'(exp_st), 2'(acq), 2'h0};
        default:                  next_rresp = acqtw_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= acqtw_pkg::RESP_OK;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

endmodule // acqtw_seq

//--- dv/acqtw_monitor.sv
// Port checker for the acquisition sequencer.
// Assumes one clock and a synchronous active-low reset.
module acqtw_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Sequencer
  input wire logic        net_ready,
  input wire logic        acq_wait_flag,
  input wire logic        exposing,
  input wire logic        reading_out,
  input wire logic        tx_active
);
  timeunit 1ns; timeprecision 1ps;
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_wait_not_exp: assert property (exposing |-> !acq_wait_flag)
    else $error("wait flag high during exposure");
  a_read_after_exp: assert property ($rose(reading_out) |-> !exposing)
    else $error("readout began during exposure");
  a_tx_needs_net: assert property ($rose(tx_active) |-> $past(net_ready))
    else $error("transmission began without link permit");
  a_tx_outlasts_read: assert property ($fell(tx_active) |-> !reading_out)
    else $error("transmission ended before readout");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  c_wait_drop: cover property ($fell(acq_wait_flag));
  c_tx_run: cover property ($fell(tx_active));
  c_read_run: cover property ($rose(reading_out));
endmodule // acqtw_monitor

bind acqtw_seq acqtw_monitor acqtw_monitor_i (.clock(clock), .rst_b(rst_b),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .net_ready(net_ready),
  .acq_wait_flag(acq_wait_flag), .exposing(exposing), .reading_out(reading_out),
  .tx_active(tx_active));

//--- dv/acqtw_partner.sv
// Trigger source and host link beside the sequencer.
// Assumes the bench commands triggers; strict low lets it overtrigger.
module acqtw_partner (
  // Commands
  input wire logic clock,
  input wire logic go,
  input wire logic strict,
  input wire logic wait_flag,
  // Pins
  output logic     trig,
  output logic     net_ready
);
  timeunit 1ns; timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  always @(posedge clock) begin
    trig <= go && (!strict || wait_flag);
    cnt <= cnt + 4'h1;
    // Link stalls one cycle in sixteen so transmission start is delayed
    net_ready <= cnt != 4'h0;
  end
endmodule // acqtw_partner

//--- dv/acq_trigger_wait_and_timing_tb.sv
// Self-checking bench of the acquisition sequencer.
// Assumes short exposure-delay and transmission-start parameters.
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, v); end end
module acq_trigger_wait_and_timing_tb;
  timeunit 1ns; timeprecision 1ps;
  logic clock = 0, rst_b = 0, go = 0, strict = 1, trig, net_ready, wf, exposing, xt = 0;
  logic aw = 0, w = 0, b = 0, ar = 0, r = 0, awr, wr_, bv, arr, rv, irq, rd, tx;
  logic [7:0] aa = 8'h00, ra = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [1:0] br, rr, rs;
  logic [3:0] lo;
  int fails = 0, checks = 0, cyc = 0;
  always #10 clock = ~clock;
  acqtw_seq #(.EXP_DLY_CYC(4), .TX_START_CYC(4)) acqtw_seq_i (.clock(clock), .rst_b(rst_b),
    .s_axi_awaddr(aa), .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(w), .s_axi_wready(wr_), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(b), .s_axi_araddr(ra), .s_axi_arvalid(ar),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(r), .ext_acq_begin_trigger_in(trig), .ext_exposure_trigger_in(xt),
    .line_out(lo), .net_ready(net_ready), .acq_wait_flag(wf), .exposing(exposing),
    .reading_out(rd), .tx_active(tx), .irq(irq));
  acqtw_partner acqtw_partner_i (.clock(clock), .go(go), .strict(strict),
    .wait_flag(wf), .trig(trig), .net_ready(net_ready));
  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    // Let an edge pass so back-to-back calls never drive a strobe twice in one step
    @(posedge clock);
    aa <= a; wd <= d; aw <= 1; w <= 1; b <= 1;
    forever begin
      @(negedge clock); ta = aw && awr; tw = w && wr_; tb = bv;
      if (tb) `CHK("bresp", acqtw_pkg::RESP_OK, br)
      @(posedge clock); if (ta) aw <= 0; if (tw) w <= 0;
      if (tb) begin b <= 0; break; end
    end
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    logic tr;
    @(posedge clock);
    ra <= a; ar <= 1; r <= 1;
    forever begin
      @(negedge clock); tr = ar && arr; d = rdat; if (rv) rs = rr;
      @(posedge clock); if (tr) ar <= 0;
      if (rv) begin r <= 0; break; end
    end
  endtask
  task automatic wt(input logic v);
    repeat (1000) begin @(negedge clock); if (wf === v) break; end
  endtask
  task automatic pulse;
    @(posedge clock); go <= 1; repeat (4) @(posedge clock); go <= 0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdr(acqtw_pkg::ADDR_CTRL, q); `CHK("ctrl", acqtw_pkg::CTRL_RST, q)
    rdr(8'h3c, q); `CHK("unmapped", acqtw_pkg::RESP_SLVERR, rs)
  endtask
  task automatic t_route;
    wr(acqtw_pkg::ADDR_FRAMES, 32'h2); wr(acqtw_pkg::ADDR_EXPOSE, 32'h40);
    wr(acqtw_pkg::ADDR_HEIGHT, 32'h1); wr(acqtw_pkg::ADDR_LINE_K, 32'h2);
    wr(acqtw_pkg::ADDR_FIXED_K, 32'h2); wr(acqtw_pkg::ADDR_TX_TIME, 32'h8);
    wr(acqtw_pkg::ADDR_MASK, 32'h1); wr(acqtw_pkg::ADDR_LINE_SEL, 32'h2);
    wr(acqtw_pkg::ADDR_LINE_SRC, 32'h1); wr(acqtw_pkg::ADDR_CTRL, 32'h13);
    wt(1); `CHK("wait", 1'b1, wf)
    `CHK("line", 4'h4, lo)
  endtask
  task automatic t_start;
    pulse(); wt(0); `CHK("wait", 1'b0, wf)
    strict <= 0; pulse(); strict <= 1;
    rdr(acqtw_pkg::ADDR_STATUS, q); `CHK("status", 4'h3, q[3:0])
    `CHK("irq", 1'b1, irq)
    wt(1); `CHK("rewait", 1'b1, wf)
    wr(acqtw_pkg::ADDR_STATUS, 32'hf); `CHK("irqclr", 1'b0, irq)
  endtask
  task automatic t_modes;
    wr(acqtw_pkg::ADDR_CTRL, 32'h12); wt(0); `CHK("legacy", 1'b0, wf)
    // Legacy mode: the exposure pin starts the acquisition
    @(posedge clock); xt <= 1; repeat (4) @(posedge clock); xt <= 0;
    rdr(acqtw_pkg::ADDR_STATE, q);
    `CHK("legacy start", 2'(acqtw_pkg::ACQ_ACTIVE), q[3:2])
    wr(acqtw_pkg::ADDR_CTRL, 32'h13); wt(1);
    wr(acqtw_pkg::ADDR_CTRL, 32'h11); wt(0); `CHK("swtrig", 4'h0, lo)
    wr(acqtw_pkg::ADDR_CMD, 32'h1); rdr(acqtw_pkg::ADDR_STATE, q);
    `CHK("sw start", 2'(acqtw_pkg::ACQ_ACTIVE), q[3:2])
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin fails++; stop_test(); end
  end
  initial begin
    repeat (3) @(posedge clock); rst_b <= 1;
    t_reset(); t_route(); t_start(); t_modes();
    stop_test();
  end
endmodule // acq_trigger_wait_and_timing_tb
